/* File: core/osb_mapper.sv */
`timescale 1ns/1ps
`default_nettype none
module osb_mapper #(
  parameter int unsigned FRAMES = osb_pkg::MF_FRAMES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       clk_en_i,
  input  wire logic       mf_start_i,
  input  wire logic [2:0] tx_bf_idx_i,
  input  wire logic       term_synced_state_i,
  input  wire logic       ps_func_en_i,
  input  wire logic       tm_func_en_i,
  input  wire logic       cold_start_only_flag_i,
  input  wire logic       primary_ok_i,
  input  wire logic       backup_ok_i,
  input  wire logic       maint_d_i,
  input  wire logic       maint_b1_i,
  input  wire logic       maint_b2_i,
  input  wire logic       rx_ovh_valid_i,
  input  wire logic [2:0] rx_bf_idx_i,
  input  wire logic       rx_ovh_bit_i,
  output logic            fourth_overhead_bit_o,
  output logic            power_status_first_o,
  output logic            power_status_second_o,
  output logic            test_mode_flag_o,
  output logic            t_if_act_req_o
);

  initial begin
    if (FRAMES != osb_pkg::MF_FRAMES) begin
      $error("osb_mapper: the multiframe must hold eight basic frames");
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic [4:0]          pins_raw;
  logic [4:0]          pins_sync;
  osb_pkg::osb_status_t live_status;
  osb_pkg::osb_status_t snap_reg;
  logic [1:0]          ps_code;
  logic                test_flag;
  logic                ovh_next;

  assign pins_raw = {primary_ok_i, backup_ok_i, maint_d_i, maint_b1_i, maint_b2_i};

  osb_sync #(
    .WIDTH (5)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .async_i   (pins_raw),
    .sync_o    (pins_sync)
  );

  always_comb begin
    live_status.primary_ok  = pins_sync[4];
    live_status.backup_ok   = pins_sync[3];
    live_status.test_active = |pins_sync[2:0];
  end

  // ----------------------------------------------------------------
  // Snapshot per multiframe.
  // ----------------------------------------------------------------
  // Sampling only at the boundary keeps the two power bits of one
  // multiframe coherent even if a supply flips between frames.
  // boundary snapshot
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      snap_reg <= osb_pkg::STATUS_RST;
    end else if (clk_en_i && mf_start_i) begin
      snap_reg <= live_status;
    end
  end

  function automatic logic [1:0] power_code(input osb_pkg::osb_status_t s);
    logic [1:0] code;
    code = osb_pkg::PS_DYING;
    unique case ({s.primary_ok, s.backup_ok})
      2'h3: code = osb_pkg::PS_ALL_OK;
      2'h2: code = osb_pkg::PS_BACKUP_BAD;
      2'h1: code = osb_pkg::PS_PRIMARY_BAD;
      2'h0: code = osb_pkg::PS_DYING;
    endcase
    return code;
  endfunction

  assign ps_code = (ps_func_en_i && term_synced_state_i) ? power_code(snap_reg)
                                                         : osb_pkg::PS_ALL_OK;
  assign test_flag = (tm_func_en_i && term_synced_state_i) ? ~snap_reg.test_active
                                                           : osb_pkg::SPARE_IDLE;

  // ----------------------------------------------------------------
  // Transmit overhead bit selection.
  // ----------------------------------------------------------------
  // Frames without an assigned use send one, as an idle spare bit.
  always_comb begin
    ovh_next = osb_pkg::SPARE_IDLE;
    unique case (tx_bf_idx_i)
      osb_pkg::BF_PS_1ST: ovh_next = ps_code[1];
      osb_pkg::BF_PS_2ND: ovh_next = ps_code[0];
      osb_pkg::BF_TEST:   ovh_next = test_flag;
      osb_pkg::BF_COLD:   ovh_next = cold_start_only_flag_i;
      default:            ovh_next = osb_pkg::SPARE_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fourth_overhead_bit_o <= osb_pkg::SPARE_IDLE;
    end else if (clk_en_i) begin
      fourth_overhead_bit_o <= ovh_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      power_status_first_o  <= osb_pkg::PS_ALL_OK[1];
      power_status_second_o <= osb_pkg::PS_ALL_OK[0];
      test_mode_flag_o      <= osb_pkg::SPARE_IDLE;
    end else if (clk_en_i) begin
      power_status_first_o  <= ps_code[1];
      power_status_second_o <= ps_code[0];
      test_mode_flag_o      <= test_flag;
    end
  end

  // ----------------------------------------------------------------
  // Receive side: activation request from the line end.
  // ----------------------------------------------------------------
  // An unused function at the far end arrives as a steady one, which
  // simply reads as a standing request to keep the T interface up.
  // request capture
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      t_if_act_req_o <= osb_pkg::ACT_REQ_RST;
    end else if (clk_en_i && rx_ovh_valid_i && (rx_bf_idx_i == osb_pkg::BF_ACT_REQ)) begin
      t_if_act_req_o <= rx_ovh_bit_i;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  a_ps_first_slot: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && tx_bf_idx_i == osb_pkg::BF_PS_1ST |=> fourth_overhead_bit_o == $past(ps_code[1]))
    else $error("First power bit not sent in its frame.");

  a_ps_all_ok: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && tx_bf_idx_i == osb_pkg::BF_PS_2ND && ps_func_en_i && term_synced_state_i
      && snap_reg.primary_ok && snap_reg.backup_ok |=> fourth_overhead_bit_o)
    else $error("Second power bit not one with both supplies normal.");

  a_ps_backup_bad: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && ps_func_en_i && term_synced_state_i && snap_reg.primary_ok && !snap_reg.backup_ok
      |=> power_status_first_o && !power_status_second_o)
    else $error("Backup failure not coded as 10.");

  a_ps_primary_bad: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && ps_func_en_i && term_synced_state_i && !snap_reg.primary_ok && snap_reg.backup_ok
      |=> !power_status_first_o && power_status_second_o)
    else $error("Primary failure not coded as 01.");

  a_ps_dying: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && ps_func_en_i && term_synced_state_i && !snap_reg.primary_ok && !snap_reg.backup_ok
      |=> !power_status_first_o && !power_status_second_o)
    else $error("Double failure not coded as 00.");

  a_ps_unused_ones: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && !ps_func_en_i |=> power_status_first_o && power_status_second_o)
    else $error("Unused power function not sending ones.");

  a_test_slot: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && tx_bf_idx_i == osb_pkg::BF_TEST |=> fourth_overhead_bit_o == $past(test_flag))
    else $error("Test-mode bit not sent in its frame.");

  a_test_polarity: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && tm_func_en_i && term_synced_state_i |=> test_mode_flag_o == !$past(snap_reg.test_active))
    else $error("Test-mode bit polarity wrong.");

  a_test_cause: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && mf_start_i && (|pins_sync[2:0]) |=> snap_reg.test_active)
    else $error("Channel maintenance not seen as test mode.");

  a_test_unused: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && !tm_func_en_i |=> test_mode_flag_o)
    else $error("Unused test-mode function not sending one.");

  a_cold_slot: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && tx_bf_idx_i == osb_pkg::BF_COLD |=> fourth_overhead_bit_o == $past(cold_start_only_flag_i))
    else $error("Capability bit not sent in frame five.");

  a_act_capture: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && rx_ovh_valid_i && rx_bf_idx_i == osb_pkg::BF_ACT_REQ |=> t_if_act_req_o == $past(rx_ovh_bit_i))
    else $error("Activation request not taken from frame seven.");

  a_snap_hold: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    !(clk_en_i && mf_start_i) |=> $stable(snap_reg))
    else $error("Status snapshot changed inside a multiframe.");

  a_ps_second_slot: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && tx_bf_idx_i == osb_pkg::BF_PS_2ND |=> fourth_overhead_bit_o == $past(ps_code[0]))
    else $error("Second power bit not sent in its frame.");

  a_idle_spare: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && (tx_bf_idx_i == 3'h0 || tx_bf_idx_i > osb_pkg::BF_COLD) |=> fourth_overhead_bit_o)
    else $error("Unassigned frame not sending one.");

  a_ps_all_ok_first: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && tx_bf_idx_i == osb_pkg::BF_PS_1ST && ps_func_en_i && term_synced_state_i
      && snap_reg.primary_ok && snap_reg.backup_ok |=> fourth_overhead_bit_o)
    else $error("First power bit not one with both supplies normal.");

  a_ps_unused_slots: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && !ps_func_en_i && (tx_bf_idx_i == osb_pkg::BF_PS_1ST || tx_bf_idx_i == osb_pkg::BF_PS_2ND)
      |=> fourth_overhead_bit_o)
    else $error("Unused power function not sending ones on the line.");

  a_test_unused_slot: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && !tm_func_en_i && tx_bf_idx_i == osb_pkg::BF_TEST |=> fourth_overhead_bit_o)
    else $error("Unused test-mode function not sending one on the line.");

  a_test_no_cause: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && mf_start_i && !(|pins_sync[2:0]) |=> !snap_reg.test_active)
    else $error("Test mode reported without channel maintenance.");

  a_cold_zero: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && tx_bf_idx_i == osb_pkg::BF_COLD && !cold_start_only_flag_i |=> !fourth_overhead_bit_o)
    else $error("Capability bit not zero for a warm-start transceiver.");

  a_snap_source: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && mf_start_i |=> snap_reg == $past(live_status))
    else $error("Snapshot not taken from the synchronised pins.");

  a_act_hold: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && !(rx_ovh_valid_i && rx_bf_idx_i == osb_pkg::BF_ACT_REQ) |=> $stable(t_if_act_req_o))
    else $error("Activation request changed outside frame seven.");

  a_act_deact: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && rx_ovh_valid_i && rx_bf_idx_i == osb_pkg::BF_ACT_REQ && !rx_ovh_bit_i |=> !t_if_act_req_o)
    else $error("Deactivation request not taken from frame seven.");

  // A frozen enable must hold every output, or the framer would see a
  // bit that belongs to no frame.
  a_freeze_outputs: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    !clk_en_i |=> $stable({fourth_overhead_bit_o, power_status_first_o, power_status_second_o,
                           test_mode_flag_o, t_if_act_req_o}))
    else $error("Outputs changed while the clock enable was low.");

  // Reset is checked without a disable clause, since the idle values
  // are exactly what reset must leave on the line.
  a_reset_idle: assert property (
    @(posedge ref_clk_i)
    srst_i |=> fourth_overhead_bit_o && power_status_first_o && power_status_second_o
      && test_mode_flag_o && !t_if_act_req_o)
    else $error("Outputs not at their idle values after reset.");

  // ----------------------------------------------------------------
  // Cover points for the main scenarios.
  // ----------------------------------------------------------------
  c_dying_sent: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && ps_func_en_i && term_synced_state_i && !snap_reg.primary_ok && !snap_reg.backup_ok);
  c_test_mode: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && tm_func_en_i && term_synced_state_i && snap_reg.test_active);
  c_deact_req: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    t_if_act_req_o ##1 !t_if_act_req_o);
  c_act_req: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    !t_if_act_req_o ##1 t_if_act_req_o);
  c_primary_out: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    clk_en_i && ps_func_en_i && term_synced_state_i && !snap_reg.primary_ok && snap_reg.backup_ok);

endmodule // osb_mapper
`default_nettype wire

/* File: core/osb_pkg.sv */
// Functional notes
// - Power status bits in frames two, three.
// - Both supplies normal: send 11.
// - Backup battery bad only: send 10.
// - Primary bad, backup normal: send 01.
// - Both supplies bad: send 00.
// - Power function unused: both bits one.
// - Test-mode bit in frame four.
// - Test-mode bit one normal, zero testing.
// - Local channel maintenance means test mode.
// - Test-mode function unused: send one.
// - Frame five carries cold-start-only capability.
package osb_pkg;

  // ----------------------------------------------------------------
  // Multiframe layout, basic frames counted from zero.
  // ----------------------------------------------------------------
  localparam int unsigned MF_FRAMES  = 8;
  localparam int unsigned BF_IDX_W   = 3;
  localparam logic [2:0]  BF_PS_1ST  = 3'h1;
  localparam logic [2:0]  BF_PS_2ND  = 3'h2;
  localparam logic [2:0]  BF_TEST    = 3'h3;
  localparam logic [2:0]  BF_COLD    = 3'h4;
  localparam logic [2:0]  BF_ACT_REQ = 3'h6;

  // ----------------------------------------------------------------
  // Values and reset states.
  // ----------------------------------------------------------------
  localparam logic [1:0]  PS_ALL_OK    = 2'h3;
  localparam logic [1:0]  PS_BACKUP_BAD = 2'h2;
  localparam logic [1:0]  PS_PRIMARY_BAD = 2'h1;
  localparam logic [1:0]  PS_DYING     = 2'h0;
  localparam logic        SPARE_IDLE   = 1'h1;
  localparam logic        ACT_REQ_RST  = 1'h0;
  localparam int unsigned SYNC_STAGES  = 2;

  // Status carried from the pins to the per-multiframe snapshot.
  typedef struct packed {
    logic primary_ok;
    logic backup_ok;
    logic test_active;
  } osb_status_t;

  localparam osb_status_t STATUS_RST = '{primary_ok: 1'h1, backup_ok: 1'h1, test_active: 1'h0};

endpackage : osb_pkg

/* File: core/osb_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module osb_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("osb_sync: WIDTH must be at least one");
    end
  end

  // ----------------------------------------------------------------
  // Two stages; the first is read only by the second.
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else if (clk_en_i) begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule // osb_sync
`default_nettype wire

/* File: tb/osb_lt_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Line end model: one overhead bit every other cycle.
// ----------------------------------------------------------------
module osb_lt_model (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       req_used_i,
  input  wire logic       req_act_i,
  output logic            ovh_valid_o,
  output logic [2:0]      bf_idx_o,
  output logic            ovh_o
);
  logic       phase_reg;
  logic [2:0] frame_reg;
  // Idle cycles show the request index with a flipped bit, so ignoring the strobe is caught.
  always @(negedge ref_clk_i) begin
    if (srst_i) begin
      phase_reg   <= 1'h0;
      frame_reg   <= 3'h0;
      ovh_valid_o <= 1'h0;
      bf_idx_o    <= 3'h6;
      ovh_o       <= 1'h0;
    end else if (phase_reg) begin
      phase_reg   <= 1'h0;
      ovh_valid_o <= 1'h0;
      bf_idx_o    <= 3'h6;
      ovh_o       <= ~ovh_o;
    end else begin
      phase_reg   <= 1'h1;
      ovh_valid_o <= 1'h1;
      bf_idx_o    <= frame_reg;
      frame_reg   <= frame_reg + 3'h1;
      ovh_o       <= (frame_reg == 3'h6) ? (req_used_i ? req_act_i : 1'h1) : ~ovh_o;
    end
  end
endmodule // osb_lt_model
`default_nettype wire

/* File: tb/overhead_spare_bit_mapper_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module overhead_spare_bit_mapper_tb;
  logic       ref_clk_i, srst_i, clk_en, mf_start, synced, ps_en, tm_en, cold_only;
  logic       pri_ok, bak_ok, mnt_d, mnt_b1, mnt_b2, rx_valid, rx_bit, req_used, req_act;
  logic [2:0] tx_idx, rx_idx;
  logic       ovh_out, pwr_a, pwr_b, tm_flag, act_req;
  logic [3:0] last_e;
  int         miscompares, n_checks;

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  osb_mapper u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .clk_en_i(clk_en), .mf_start_i(mf_start),
    .tx_bf_idx_i(tx_idx), .term_synced_state_i(synced), .ps_func_en_i(ps_en), .tm_func_en_i(tm_en),
    .cold_start_only_flag_i(cold_only), .primary_ok_i(pri_ok), .backup_ok_i(bak_ok), .maint_d_i(mnt_d),
    .maint_b1_i(mnt_b1), .maint_b2_i(mnt_b2), .rx_ovh_valid_i(rx_valid), .rx_bf_idx_i(rx_idx),
    .rx_ovh_bit_i(rx_bit), .fourth_overhead_bit_o(ovh_out), .power_status_first_o(pwr_a),
    .power_status_second_o(pwr_b), .test_mode_flag_o(tm_flag), .t_if_act_req_o(act_req));

  osb_lt_model u_lt (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_used_i(req_used), .req_act_i(req_act),
    .ovh_valid_o(rx_valid), .bf_idx_o(rx_idx), .ovh_o(rx_bit));

  // ----------------------------------------------------------------
  // Checking and closing.
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic exp_bit(input int p, input logic [3:0] e);
    return (p == 1) ? e[3] : (p == 2) ? e[2] : (p == 3) ? e[1] : (p == 4) ? e[0] : 1'b1;
  endfunction

  // One multiframe of indices; e holds first power, second power, test and cold-start bits.
  task automatic run_mf(input logic chk_on, input logic [3:0] e);
    for (int i = 0; i <= 8; i++) begin
      @(negedge ref_clk_i);
      if (chk_on && i > 0) chk({7'h0, ovh_out}, {7'h0, exp_bit(i - 1, e)});
      mf_start = (i == 0);
      tx_idx   = 3'(i);
    end
    if (chk_on) chk({5'h0, pwr_a, pwr_b, tm_flag}, {5'h0, e[3:1]});
  endtask

  // Pins change between boundaries first, so the outputs must hold the previous snapshot.
  task automatic apply(input logic [4:0] pins, input logic [3:0] e);
    @(negedge ref_clk_i);
    {pri_ok, bak_ok, mnt_d, mnt_b1, mnt_b2} = pins;
    repeat (6) @(negedge ref_clk_i);
    chk({5'h0, pwr_a, pwr_b, tm_flag}, {5'h0, last_e[3:1]});
    run_mf(1'b0, e);
    run_mf(1'b1, e);
    last_e = e;
  endtask

  task automatic wait_req(input logic exp);
    int n;
    n = 0;
    while (act_req !== exp && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk({7'h0, act_req}, {7'h0, exp});
    if (n >= 40) conclude();
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    {srst_i, clk_en, mf_start, synced, ps_en, tm_en, cold_only} = 7'h6E;
    {pri_ok, bak_ok, mnt_d, mnt_b1, mnt_b2} = 5'h18;
    {tx_idx, req_used, req_act} = 5'h2;
    {miscompares, n_checks} = '0;
    last_e = 4'hE;
    repeat (4) @(negedge ref_clk_i);
    srst_i = 1'b0;
    chk({3'h0, ovh_out, pwr_a, pwr_b, tm_flag, act_req}, 8'h1E);
    $display("test reset done");
    for (int k = 3; k >= 0; k--) apply({2'(k), 3'h0}, {2'(k), 2'h2});
    $display("test power codes done");
    for (int k = 0; k < 3; k++) apply({2'h3, 3'(1 << k)}, 4'hC);
    $display("test maintenance done");
    @(negedge ref_clk_i);
    clk_en = 1'b0;
    tx_idx = 3'h3;
    repeat (3) @(negedge ref_clk_i);
    chk({7'h0, ovh_out}, 8'h1);
    clk_en = 1'b1;
    @(negedge ref_clk_i);
    chk({7'h0, ovh_out}, 8'h0);
    $display("test freeze done");
    {ps_en, tm_en, cold_only} = 3'h1;
    last_e = 4'hF;
    apply(5'h07, 4'hF);
    {ps_en, tm_en, synced} = 3'h6;
    apply(5'h04, 4'hF);
    $display("test unused functions done");
    {req_used, req_act} = 2'h3;
    wait_req(1'b1);
    req_act = 1'b0;
    wait_req(1'b0);
    req_used = 1'b0;
    wait_req(1'b1);
    $display("test activation request done");
    conclude();
  end
endmodule // overhead_spare_bit_mapper_tb
`default_nettype wire
